// [hw/serial_port.sv]
// Serial port with two 256-entry FIFOs behind an APB slave.
// Assumes pclk at 40 MHz and an RS-232 transceiver on the line pins.
`timescale 1ns/1ps
`include "serial_port_params.svh"

// ==========================================================================
// Character FIFO
module serial_fifo
#(
   parameter int WIDTH = 8,
   parameter int AW    = 8
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Fill side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] din,
   // Drain side
   input  wire logic             pop,
   output logic      [WIDTH-1:0] dout,
   output logic      [AW:0]      count
);
   logic [WIDTH-1:0] mem_reg [0:(1<<AW)-1];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             do_push;
   logic             do_pop;

   // A push on a full FIFO is lost; a pop on an empty one does nothing.
   assign do_push = push && (count_reg != (AW+1)'(1 << AW));
   assign do_pop  = pop && (count_reg != '0);
   assign dout    = mem_reg[rd_ptr_reg];
   assign count   = count_reg;

   always_ff @(posedge pclk)
   begin
      if (do_push)
         mem_reg[wr_ptr_reg] <= din;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_push && !do_pop)
            count_reg <= count_reg + 1'b1;
         else if (do_pop && !do_push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

// ==========================================================================
// Serial port top
module serial_port
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Line transceiver
   input  wire logic        serial_rxd,
   output logic             serial_txd,
   // Processor interrupt
   output logic             irq
);
   localparam logic [15:0] BIT_CYC  = 16'(`BIT_CYCLES - 1);
   localparam logic [15:0] HALF_CYC = 16'(`HALF_CYCLES - 1);

   logic [31:0] prdata_reg;
   logic        rx_ie_reg;
   logic        tx_ie_reg;
   logic        irq_reg;
   logic        hit_data;
   logic        hit_data_hi;
   logic        hit_ctrl;
   logic        setup_ph;
   logic        access_ph;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_push;
   logic        rx_pop;
   logic [8:0]  tx_count;
   logic [8:0]  tx_free;
   logic [7:0]  tx_head;
   logic [8:0]  rx_count;
   logic [8:0]  rx_head;
   logic [8:0]  rx_push_data;
   logic        rx_ip;
   logic        tx_ip;

   // =======================================================================
   // APB decode
   assign hit_data    = (paddr == `DATA_ADDR);
   assign hit_data_hi = (paddr == `DATA_HI_ADDR);
   assign hit_ctrl    = (paddr == `CTRL_ADDR);
   assign setup_ph    = psel && !penable;
   assign access_ph   = psel && penable;
   assign pready      = 1'b1;
   assign pslverr     = access_ph &&
                        (!(hit_data || hit_data_hi || hit_ctrl) ||
                         (pwrite && hit_data_hi));
   assign prdata      = prdata_reg;
   assign irq         = irq_reg;

   assign tx_free = `FIFO_DEPTH - tx_count;
   assign rx_ip   = rx_ie_reg && (rx_count > `IRQ_LEVEL);
   assign tx_ip   = tx_ie_reg && (tx_free > `IRQ_LEVEL);

   // Pushes take only the low byte lane; other lanes carry nothing.
   assign tx_push = access_ph && pwrite && hit_data && pstrb[0];
   // The pop is gated by the valid bit captured in setup, so a character
   // landing in an empty FIFO during the access is never lost unread.
   assign rx_pop  = access_ph && !pwrite && hit_data &&
                    prdata_reg[`RX_VALID_BIT];

   // Read data is captured in setup and stands through the access phase.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h00000000;
      else if (setup_ph && !pwrite)
      begin
         if (hit_data || hit_data_hi)
            prdata_reg <= {7'h00, rx_count, (rx_count != 9'h000), 5'h00,
                           rx_head[8], 1'b0, rx_head[7:0]};
         else if (hit_ctrl)
            prdata_reg <= {7'h00, tx_free, 6'h00, tx_ip, rx_ip,
                           6'h00, tx_ie_reg, rx_ie_reg};
         else
            prdata_reg <= 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_ie_reg <= `IE_RESET;
         tx_ie_reg <= `IE_RESET;
      end
      else if (access_ph && pwrite && hit_ctrl && pstrb[0])
      begin
         rx_ie_reg <= pwdata[`RX_IE_BIT];
         tx_ie_reg <= pwdata[`TX_IE_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= rx_ip || tx_ip;
   end

   // =======================================================================
   // FIFOs
   serial_fifo #(.WIDTH(8), .AW(`FIFO_AW)) u_tx_fifo
   (
      .pclk    (pclk),
      .presetn (presetn),
      .push    (tx_push),
      .din     (pwdata[7:0]),
      .pop     (tx_pop),
      .dout    (tx_head),
      .count   (tx_count)
   );

   serial_fifo #(.WIDTH(9), .AW(`FIFO_AW)) u_rx_fifo
   (
      .pclk    (pclk),
      .presetn (presetn),
      .push    (rx_push),
      .din     (rx_push_data),
      .pop     (rx_pop),
      .dout    (rx_head),
      .count   (rx_count)
   );

   // =======================================================================
   // Transmitter
   serial_port_pkg::tx_state_t tx_state_reg;
   logic [15:0] tx_tick_reg;
   logic [2:0]  tx_bit_reg;
   logic [7:0]  tx_shift_reg;
   logic        tx_par_reg;
   logic        txd_reg;

   assign tx_pop     = (tx_state_reg == serial_port_pkg::TX_IDLE) &&
                       (tx_count != 9'h000);
   assign serial_txd = txd_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state_reg <= serial_port_pkg::TX_IDLE;
         tx_tick_reg  <= 16'h0000;
         tx_bit_reg   <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_par_reg   <= 1'b0;
         txd_reg      <= 1'b1;
      end
      else if (tx_state_reg == serial_port_pkg::TX_IDLE)
      begin
         txd_reg <= 1'b1;
         if (tx_pop)
         begin
            tx_shift_reg <= tx_head;
            tx_par_reg   <= ~^tx_head;
            txd_reg      <= 1'b0;
            tx_tick_reg  <= BIT_CYC;
            tx_state_reg <= serial_port_pkg::TX_START;
         end
      end
      else if (tx_tick_reg != 16'h0000)
         tx_tick_reg <= tx_tick_reg - 16'h0001;
      else
      begin
         tx_tick_reg <= BIT_CYC;
         case (tx_state_reg)
            serial_port_pkg::TX_START:
            begin
               txd_reg      <= tx_shift_reg[0];
               tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
               tx_bit_reg   <= 3'h0;
               tx_state_reg <= serial_port_pkg::TX_DATA;
            end
            serial_port_pkg::TX_DATA:
            begin
               if (tx_bit_reg == 3'h7)
               begin
                  txd_reg      <= tx_par_reg;
                  tx_state_reg <= serial_port_pkg::TX_PARITY;
               end
               else
               begin
                  txd_reg      <= tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_bit_reg   <= tx_bit_reg + 3'h1;
               end
            end
            serial_port_pkg::TX_PARITY:
            begin
               txd_reg      <= 1'b1;
               tx_state_reg <= serial_port_pkg::TX_STOP;
            end
            default:
               tx_state_reg <= serial_port_pkg::TX_IDLE;
         endcase
      end
   end

   // =======================================================================
   // Receiver
   serial_port_pkg::rx_state_t rx_state_reg;
   logic        rxd_meta_reg;
   logic        rxd_sync_reg;
   logic [15:0] rx_tick_reg;
   logic [2:0]  rx_bit_reg;
   logic [7:0]  rx_shift_reg;
   logic        rx_par_reg;
   logic        rx_push_reg;

   assign rx_push      = rx_push_reg;
   // A frame with a bad stop bit is still kept; only parity is reported.
   assign rx_push_data = {~^{rx_shift_reg, rx_par_reg}, rx_shift_reg};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end
      else
      begin
         rxd_meta_reg <= serial_rxd;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state_reg <= serial_port_pkg::RX_IDLE;
         rx_tick_reg  <= 16'h0000;
         rx_bit_reg   <= 3'h0;
         rx_shift_reg <= 8'h00;
         rx_par_reg   <= 1'b0;
         rx_push_reg  <= 1'b0;
      end
      else
      begin
         rx_push_reg <= 1'b0;
         if (rx_state_reg == serial_port_pkg::RX_IDLE)
         begin
            if (!rxd_sync_reg)
            begin
               rx_tick_reg  <= HALF_CYC;
               rx_state_reg <= serial_port_pkg::RX_START;
            end
         end
         else if (rx_tick_reg != 16'h0000)
            rx_tick_reg <= rx_tick_reg - 16'h0001;
         else
         begin
            rx_tick_reg <= BIT_CYC;
            case (rx_state_reg)
               serial_port_pkg::RX_START:
               begin
                  rx_bit_reg <= 3'h0;
                  // A glitch shorter than half a bit is not a start bit.
                  if (rxd_sync_reg)
                     rx_state_reg <= serial_port_pkg::RX_IDLE;
                  else
                     rx_state_reg <= serial_port_pkg::RX_DATA;
               end
               serial_port_pkg::RX_DATA:
               begin
                  rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
                  rx_bit_reg   <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == 3'h7)
                     rx_state_reg <= serial_port_pkg::RX_PARITY;
               end
               serial_port_pkg::RX_PARITY:
               begin
                  rx_par_reg   <= rxd_sync_reg;
                  rx_state_reg <= serial_port_pkg::RX_STOP;
               end
               default:
               begin
                  rx_push_reg  <= 1'b1;
                  rx_state_reg <= serial_port_pkg::RX_IDLE;
               end
            endcase
         end
      end
   end

   // =======================================================================
   // Checks
   chk_rx_count_field: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && hit_data) |=>
         (prdata[31:16] == {7'h00, $past(rx_count)}))
      else $error("receive count field wrong");

   chk_tx_space_field: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && hit_ctrl) |=>
         (prdata[31:16] == {7'h00, `FIFO_DEPTH - $past(tx_count)}))
      else $error("transmit space field wrong");

   chk_rx_full_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_count == `FIFO_DEPTH && rx_push && !rx_pop) |=>
         (rx_count == `FIFO_DEPTH))
      else $error("full receive FIFO changed");

   chk_tx_full_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_count == `FIFO_DEPTH && tx_push && !tx_pop) |=>
         (tx_count == `FIFO_DEPTH))
      else $error("full transmit FIFO changed");

   chk_tx_push_count: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_push && !tx_pop && tx_count != `FIFO_DEPTH) |=>
         (tx_count == $past(tx_count) + 9'h001))
      else $error("data write did not push");

   chk_write_no_rx: assert property (@(posedge pclk) disable iff (!presetn)
      (access_ph && pwrite && hit_data && !rx_push) |=>
         $stable(rx_count))
      else $error("data write touched receive FIFO");

   chk_hi_read_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (access_ph && !pwrite && hit_data_hi && !rx_push) |=>
         $stable(rx_count))
      else $error("upper halfword read popped");

   chk_pop_decrement: assert property (@(posedge pclk) disable iff (!presetn)
      (access_ph && !pwrite && hit_data && prdata[`RX_VALID_BIT] &&
       !rx_push) |=> (rx_count == $past(rx_count) - 9'h001))
      else $error("data read did not decrement");

   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_ie_reg && rx_count > `IRQ_LEVEL) |=> irq)
      else $error("receive interrupt missing");

   chk_tx_irq_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tx_ie_reg && tx_free > `IRQ_LEVEL) |=> irq)
      else $error("transmit interrupt missing");

   chk_irq_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!rx_ip && !tx_ip) |=> !irq)
      else $error("interrupt did not clear");

   chk_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_pop) |=> (!serial_txd)[*8])
      else $error("start bit not low");
endmodule

// [hw/serial_port_params.svh]
// Constants for the serial port: addresses, fields, reset values, timing.
// Assumes inclusion by bare name from the port module or the testbench.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// ==========================================================================
// Register addresses
`define DATA_ADDR      32'h10001010
`define DATA_HI_ADDR   32'h10001012
`define CTRL_ADDR      32'h10001014

// ==========================================================================
// Field positions and reset values
`define RX_VALID_BIT   15
`define PERR_BIT       9
`define RX_IE_BIT      0
`define TX_IE_BIT      1
`define RX_IP_BIT      8
`define TX_IP_BIT      9
`define IE_RESET       1'h0

// ==========================================================================
// FIFO sizing and interrupt level
`define FIFO_AW        8
`define FIFO_DEPTH     9'h100
`define IRQ_LEVEL      9'h01F

// ==========================================================================
// Timing
`define CLK_HZ         40000000
`define BAUD_RATE      115200
`define BIT_CYCLES     ((`CLK_HZ + (`BAUD_RATE / 2)) / `BAUD_RATE)
`define HALF_CYCLES    (`BIT_CYCLES / 2)

`endif

// [hw/serial_port_pkg.sv]
// Types shared by the serial port logic.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_port_pkg;

   // =======================================================================
   // Transmit and receive state machines
   typedef enum logic [4:0]
   {
      TX_IDLE   = 5'h01,
      TX_START  = 5'h02,
      TX_DATA   = 5'h04,
      TX_PARITY = 5'h08,
      TX_STOP   = 5'h10
   } tx_state_t;

   typedef enum logic [4:0]
   {
      RX_IDLE   = 5'h01,
      RX_START  = 5'h02,
      RX_DATA   = 5'h04,
      RX_PARITY = 5'h08,
      RX_STOP   = 5'h10
   } rx_state_t;

endpackage

// [verif/line_partner.sv]
// Behavioural far side of the serial port: a terminal behind a transceiver.
// Assumes pclk is the bench clock and BIT clock cycles in one bit period.
`timescale 1ns/1ps

module line_partner
#(
   parameter int BIT = 347
)
(
   // Clock
   input  wire logic pclk,
   // Line pins
   input  wire logic serial_txd,
   output logic      serial_rxd
);
   logic [7:0] got_char;
   logic       got_par_ok;
   logic       got_stop;
   int         got_count;
   int         i;

   // =======================================================================
   // Terminal sends one frame; a set bad flag inverts the parity bit.
   task automatic send_char(input logic [7:0] c, input logic bad);
      logic [10:0] fr;
      fr = {1'h1, (~(^c)) ^ bad, c, 1'h0};
      for (int b = 0; b < 11; b++)
      begin
         serial_rxd <= fr[b];
         repeat (BIT) @(posedge pclk);
      end
   endtask

   // =======================================================================
   // Terminal receiver, sampling mid-bit after each falling start edge.
   initial
   begin
      serial_rxd = 1'h1;
      got_count  = 0;
      forever
      begin
         @(negedge serial_txd);
         repeat (BIT / 2) @(posedge pclk);
         for (i = 0; i < 8; i++)
         begin
            repeat (BIT) @(posedge pclk);
            got_char[i] = serial_txd;
         end
         repeat (BIT) @(posedge pclk);
         got_par_ok = ^{got_char, serial_txd};
         repeat (BIT) @(posedge pclk);
         got_stop = serial_txd;
         got_count++;
      end
   end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the serial port: APB master plus line partner.
// Assumes the design files and the shared constants header are compiled.
`timescale 1ns/1ps
`include "serial_port_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
 $display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end

module testbench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serial_rxd;
   logic        serial_txd;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          bad_count;
   int          total_checks;

   // =======================================================================
   // Instances
   serial_port serial_port_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_rxd(serial_rxd),
      .serial_txd(serial_txd), .irq(irq));
   line_partner line_partner_inst (.pclk(pclk), .serial_txd(serial_txd),
      .serial_rxd(serial_rxd));

   // =======================================================================
   // Closing report and bus tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One edge passes after release so the next setup never reassigns psel.
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      int n;
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= 4'hF;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      if (n >= 50)
      begin
         bad_count++;
         wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wait_tx(input int n);
      int k;
      k = 0;
      while (line_partner_inst.got_count < n && k < 6000)
      begin
         @(posedge pclk);
         k++;
      end
      if (k >= 6000)
      begin
         bad_count++;
         wrap_up;
      end
   endtask

   // =======================================================================
   // Scenarios
   task automatic t_reset;
      apb(1'h0, `DATA_ADDR, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'h0, `CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h01000000)
      apb(1'h0, 32'h10001018, 32'h0);
      `CHK(err, 1'h1)
      `CHK(irq, 1'h0)
   endtask

   // Bits above 7 of the written word must not reach the line.
   task automatic t_tx;
      apb(1'h1, `DATA_ADDR, 32'h000001C5);
      wait_tx(1);
      `CHK(line_partner_inst.got_char, 8'hC5)
      `CHK(line_partner_inst.got_par_ok, 1'h1)
      `CHK(line_partner_inst.got_stop, 1'h1)
   endtask

   task automatic t_rx;
      line_partner_inst.send_char(8'h5A, 1'h0);
      line_partner_inst.send_char(8'h3C, 1'h1);
      apb(1'h1, `DATA_ADDR, 32'h00000077);
      apb(1'h0, `DATA_HI_ADDR, 32'h0);
      `CHK(rd, 32'h0002805A)
      apb(1'h0, `DATA_HI_ADDR, 32'h0);
      `CHK(rd, 32'h0002805A)
      apb(1'h0, `DATA_ADDR, 32'h0);
      `CHK(rd, 32'h0002805A)
      apb(1'h0, `DATA_ADDR, 32'h0);
      `CHK(rd, 32'h0001823C)
      apb(1'h0, `DATA_ADDR, 32'h0);
      `CHK(rd[31:15], 17'h00000)
      wait_tx(2);
      `CHK(line_partner_inst.got_char, 8'h77)
   endtask

   // Transmitter, still in the stop bit of the 0x77 frame, takes one write partway through the 225, leaving 32 free entries.
   task automatic t_irq;
      apb(1'h1, `CTRL_ADDR, 32'h00000003);
      apb(1'h0, `CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h01000203)
      `CHK(irq, 1'h1)
      for (int j = 0; j < 225; j++)
         apb(1'h1, `DATA_ADDR, 32'h00000030);
      apb(1'h0, `CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h00200203)
      apb(1'h1, `DATA_ADDR, 32'h00000031);
      apb(1'h0, `CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h001F0003)
      `CHK(irq, 1'h0)
      for (int j = 0; j < 40; j++)
         apb(1'h1, `DATA_ADDR, 32'h00000032);
      apb(1'h0, `CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h00000003)
      apb(1'h0, `DATA_ADDR, 32'h0);
      `CHK(rd[31:15], 17'h00000)
   endtask

   // =======================================================================
   // Clock and main sequence
   initial
   begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end

   initial
   begin
      presetn      = 1'h0;
      psel         = 1'h0;
      penable      = 1'h0;
      pwrite       = 1'h0;
      paddr        = 32'h0;
      pwdata       = 32'h0;
      pstrb        = 4'h0;
      bad_count    = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_reset;
      t_tx;
      t_rx;
      t_irq;
      wrap_up;
   end
endmodule
